// ---- design/fci_host.sv ----
// Host sequencer that drives a parallel flash command interface
// Notes on behaviour
// - Count, N+1 data words, then confirm
// - Buffer count refused if crossing boundary
// - Poll extended status before sending count
// - Only defined codes are ever written
// - Byte mode drives lowest address bit
`timescale 1ns/100ps
`default_nettype none
module fci_host (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic reqValid,
   output logic reqReady,
   input wire fci_pkg::fci_op_e reqOp,
   input wire logic [21:0] reqAddr,
   input wire logic [15:0] reqData,
   input wire logic [4:0] reqCount,
   input wire logic byteMode,
   input wire logic protectHigh,
   input wire logic wrValid,
   output logic wrReady,
   input wire logic [15:0] wrData,
   output logic rspValid,
   output logic rspError,
   output logic [15:0] rspData,
   output logic flashCeN,
   output logic flashOeN,
   output logic flashWeN,
   output logic [21:0] flashAddr,
   output logic [15:0] flashDqOut,
   output logic flashDqOe,
   input wire logic [15:0] flashDqIn,
   output logic flashByteN,
   output logic flashRpN,
   output logic flashWp
);
   fci_cyc_if cycIf ();
   fci_pkg::fci_state_e state_r;
   fci_pkg::fci_op_e op_r;
   logic [21:0] addr_r;
   logic [21:0] dataAddr_r;
   logic [15:0] data_r;
   logic [4:0] count_r;
   logic [4:0] left_r;
   logic [7:0] lowByte_r;
   logic [7:0] rpCnt_r;
   logic readHi_r, pending_r, modeArray_r, busyOp_r, suspended_r;
   logic accept, busState, fits, lockOp;
   logic [5:0] sum;
   logic [21:0] readOff;
   logic [7:0] firstCode;
   logic [15:0] argData;

   fci_bus_cycle u_cycle (
      .clock(clock), .rst_b(rst_b), .cyc(cycIf.cyc),
      .pinCeN(flashCeN), .pinOeN(flashOeN), .pinWeN(flashWeN),
      .pinAddr(flashAddr), .pinDqOut(flashDqOut), .pinDqOe(flashDqOe),
      .pinDqIn(flashDqIn)
   );

   always_comb begin
      unique case (op_r)
         fci_pkg::OP_READ_ARRAY: firstCode = fci_pkg::CMD_READ_ARRAY;
         fci_pkg::OP_READ_ID: firstCode = fci_pkg::CMD_READ_ID;
         fci_pkg::OP_READ_QUERY: firstCode = fci_pkg::CMD_QUERY;
         fci_pkg::OP_READ_STATUS: firstCode = fci_pkg::CMD_STATUS;
         fci_pkg::OP_CLEAR_STATUS: firstCode = fci_pkg::CMD_CLR_STATUS;
         fci_pkg::OP_PROGRAM: firstCode = fci_pkg::CMD_PROGRAM;
         fci_pkg::OP_BUFFER_WRITE: firstCode = fci_pkg::CMD_BUFFER;
         fci_pkg::OP_BLOCK_ERASE: firstCode = fci_pkg::CMD_ERASE;
         fci_pkg::OP_CHIP_ERASE: firstCode = fci_pkg::CMD_CHIP_ERASE;
         fci_pkg::OP_SUSPEND: firstCode = fci_pkg::CMD_SUSPEND;
         fci_pkg::OP_RESUME: firstCode = fci_pkg::CMD_CONFIRM;
         fci_pkg::OP_PIN_CONFIG: firstCode = fci_pkg::CMD_PIN_CFG;
         default: firstCode = fci_pkg::CMD_LOCK;
      endcase
      unique case (op_r)
         fci_pkg::OP_PROGRAM: argData = data_r;
         fci_pkg::OP_PIN_CONFIG: argData = {8'h00, data_r[7:0]};
         fci_pkg::OP_SET_LOCK: argData = {8'h00, fci_pkg::CMD_LOCK_SET};
         default: argData = {8'h00, fci_pkg::CMD_CONFIRM};
      endcase
   end

   assign lockOp = reqOp == fci_pkg::OP_SET_LOCK ||
      reqOp == fci_pkg::OP_CLEAR_LOCKS;
   // Boundary check for the buffered count
   assign sum = byteMode ? 6'({1'b0, reqAddr[4:0]} + {1'b0, reqCount}) :
      6'({2'b00, reqAddr[3:0]} + {1'b0, reqCount});
   assign fits = sum < (byteMode ? 6'h20 : 6'h10);
   assign reqReady = state_r == fci_pkg::ST_IDLE && flashRpN;
   assign accept = reqValid && reqReady;
   assign busState = state_r != fci_pkg::ST_IDLE &&
      state_r != fci_pkg::ST_DONE;
   assign readOff = addr_r + {21'h00000, readHi_r};
   assign cycIf.start = busState && !pending_r && !cycIf.busy &&
      (state_r != fci_pkg::ST_DATA || wrValid);
   assign wrReady = state_r == fci_pkg::ST_DATA && cycIf.start;
   assign cycIf.isWrite = state_r != fci_pkg::ST_POLL &&
      state_r != fci_pkg::ST_READ;

   always_comb begin
      cycIf.addr = addr_r;
      cycIf.wdata = {8'h00, firstCode};
      unique case (state_r)
         fci_pkg::ST_CNT: cycIf.wdata = {11'h000, count_r};
         fci_pkg::ST_DATA: begin
            cycIf.addr = dataAddr_r;
            cycIf.wdata = wrData;
         end
         fci_pkg::ST_ARG: cycIf.wdata = argData;
         fci_pkg::ST_READ: if (byteMode && op_r != fci_pkg::OP_READ_STATUS)
            cycIf.addr = {readOff[20:0], 1'b0};
         else
            cycIf.addr = readOff;
         default: ;
      endcase
   end

   // Reset pulse on the flash, then read array is the known mode
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rpCnt_r <= 8'h00;
         flashRpN <= 1'b0;
         flashByteN <= 1'b1;
      end else begin
         flashByteN <= !byteMode;
         if (rpCnt_r != 8'(fci_pkg::RP_CYC))
            rpCnt_r <= rpCnt_r + 8'h01;
         else
            flashRpN <= 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         flashWp <= 1'b0;
      end else if (accept) begin
         flashWp <= lockOp || protectHigh;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b)
         pending_r <= 1'b0;
      else if (cycIf.start)
         pending_r <= 1'b1;
      else if (cycIf.done)
         pending_r <= 1'b0;
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= fci_pkg::ST_IDLE;
         op_r <= fci_pkg::OP_READ_ARRAY;
         addr_r <= 22'h000000;
         dataAddr_r <= 22'h000000;
         data_r <= 16'h0000;
         count_r <= 5'h00;
         left_r <= 5'h00;
         readHi_r <= 1'b0;
         lowByte_r <= 8'h00;
         rspValid <= 1'b0;
         rspError <= 1'b0;
         rspData <= 16'h0000;
      end else begin
         rspValid <= 1'b0;
         unique case (state_r)
            fci_pkg::ST_IDLE: if (accept) begin
               op_r <= reqOp;
               addr_r <= reqAddr;
               dataAddr_r <= reqAddr;
               data_r <= reqData;
               count_r <= reqCount;
               readHi_r <= 1'b0;
               rspError <= 1'b0;
               state_r <= fci_pkg::ST_CMD;
               if (reqOp == fci_pkg::OP_READ_ARRAY) begin
                  if (busyOp_r && !suspended_r) begin
                     rspError <= 1'b1;
                     state_r <= fci_pkg::ST_DONE;
                  end else if (modeArray_r)
                     state_r <= fci_pkg::ST_DONE;
               end
               if (reqOp == fci_pkg::OP_BUFFER_WRITE && !fits) begin
                  rspError <= 1'b1;
                  state_r <= fci_pkg::ST_DONE;
               end
            end
            fci_pkg::ST_CMD: if (cycIf.done) begin
               unique case (op_r)
                  fci_pkg::OP_READ_ID, fci_pkg::OP_READ_QUERY,
                  fci_pkg::OP_READ_STATUS: state_r <= fci_pkg::ST_READ;
                  fci_pkg::OP_BUFFER_WRITE: state_r <= fci_pkg::ST_POLL;
                  fci_pkg::OP_PROGRAM, fci_pkg::OP_BLOCK_ERASE,
                  fci_pkg::OP_CHIP_ERASE, fci_pkg::OP_SET_LOCK,
                  fci_pkg::OP_CLEAR_LOCKS, fci_pkg::OP_PIN_CONFIG:
                     state_r <= fci_pkg::ST_ARG;
                  default: state_r <= fci_pkg::ST_DONE;
               endcase
            end
            fci_pkg::ST_POLL: if (cycIf.done) begin
               state_r <= cycIf.rdata[fci_pkg::READY_BIT] ?
                  fci_pkg::ST_CNT : fci_pkg::ST_CMD;
            end
            fci_pkg::ST_CNT: if (cycIf.done) begin
               left_r <= count_r;
               state_r <= fci_pkg::ST_DATA;
            end
            fci_pkg::ST_DATA: if (cycIf.done) begin
               dataAddr_r <= dataAddr_r + 22'h000001;
               left_r <= left_r - 5'h01;
               if (left_r == 5'h00)
                  state_r <= fci_pkg::ST_ARG;
            end
            fci_pkg::ST_ARG: if (cycIf.done)
               state_r <= fci_pkg::ST_DONE;
            fci_pkg::ST_READ: if (cycIf.done) begin
               if (op_r == fci_pkg::OP_READ_QUERY && !readHi_r) begin
                  readHi_r <= 1'b1;
                  lowByte_r <= cycIf.rdata[7:0];
               end else begin
                  rspData <= op_r == fci_pkg::OP_READ_QUERY ?
                     {cycIf.rdata[7:0], lowByte_r} : cycIf.rdata;
                  state_r <= fci_pkg::ST_DONE;
               end
            end
            fci_pkg::ST_DONE: begin
               rspValid <= 1'b1;
               state_r <= fci_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Host view of the device mode and of its running operation
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         modeArray_r <= 1'b1;
         busyOp_r <= 1'b0;
         suspended_r <= 1'b0;
      end else if (cycIf.done) begin
         if (state_r == fci_pkg::ST_CMD) begin
            modeArray_r <= op_r == fci_pkg::OP_READ_ARRAY;
            if (op_r == fci_pkg::OP_SUSPEND && busyOp_r)
               suspended_r <= 1'b1;
            if (op_r == fci_pkg::OP_RESUME && suspended_r)
               suspended_r <= 1'b0;
         end
         if (state_r == fci_pkg::ST_ARG && op_r != fci_pkg::OP_PIN_CONFIG)
            busyOp_r <= 1'b1;
         if (state_r == fci_pkg::ST_READ && op_r == fci_pkg::OP_READ_STATUS
            && cycIf.rdata[fci_pkg::READY_BIT] && !suspended_r)
            busyOp_r <= 1'b0;
      end
   end

   a_cmd_upper_zero: assert property (
      @(posedge clock) disable iff (!rst_b)
      cycIf.start && state_r == fci_pkg::ST_CMD |->
      cycIf.wdata[15:8] == 8'h00)
      else $error("command write with nonzero upper byte");
   a_prog_setup: assert property (
      @(posedge clock) disable iff (!rst_b)
      cycIf.start && state_r == fci_pkg::ST_CMD &&
      op_r == fci_pkg::OP_PROGRAM |-> cycIf.wdata[7:0] ==
      fci_pkg::CMD_PROGRAM || cycIf.wdata[7:0] == fci_pkg::CMD_PROGRAM_ALT)
      else $error("bad program setup code");
   a_buf_confirm: assert property (
      @(posedge clock) disable iff (!rst_b)
      cycIf.start && state_r == fci_pkg::ST_ARG &&
      op_r == fci_pkg::OP_BUFFER_WRITE |-> cycIf.wdata[7:0] ==
      fci_pkg::CMD_CONFIRM && dataAddr_r == addr_r + 22'(count_r) + 22'h1)
      else $error("buffer confirm at wrong position");
   a_buf_bound: assert property (
      @(posedge clock) disable iff (!rst_b)
      state_r == fci_pkg::ST_CNT |-> (byteMode ?
      6'(addr_r[4:0]) + 6'(count_r) < 6'h20 :
      6'(addr_r[3:0]) + 6'(count_r) < 6'h10))
      else $error("buffer count crosses boundary");
   a_poll_first: assert property (
      @(posedge clock) disable iff (!rst_b)
      $rose(state_r == fci_pkg::ST_CNT) |->
      $past(state_r) == fci_pkg::ST_POLL &&
      $past(cycIf.rdata[fci_pkg::READY_BIT]))
      else $error("count sent without buffer available");
   a_erase_confirm: assert property (
      @(posedge clock) disable iff (!rst_b)
      cycIf.start && state_r == fci_pkg::ST_ARG &&
      (op_r == fci_pkg::OP_BLOCK_ERASE || op_r == fci_pkg::OP_CHIP_ERASE)
      |-> cycIf.wdata == {8'h00, fci_pkg::CMD_CONFIRM})
      else $error("erase without confirm");
   a_lock_wp: assert property (
      @(posedge clock) disable iff (!rst_b)
      busState && (op_r == fci_pkg::OP_SET_LOCK ||
      op_r == fci_pkg::OP_CLEAR_LOCKS) |-> flashWp)
      else $error("lock operation with protect low");
   a_array_refuse: assert property (
      @(posedge clock) disable iff (!rst_b)
      accept && reqOp == fci_pkg::OP_READ_ARRAY && busyOp_r && !suspended_r
      |-> ##2 rspValid && rspError)
      else $error("read array not refused while busy");
   a_query_even: assert property (
      @(posedge clock) disable iff (!rst_b)
      cycIf.start && state_r == fci_pkg::ST_READ && byteMode &&
      op_r == fci_pkg::OP_READ_QUERY |-> !cycIf.addr[0])
      else $error("byte mode query on odd address");

   c_program: cover property (@(posedge clock) disable iff (!rst_b)
      state_r == fci_pkg::ST_ARG && op_r == fci_pkg::OP_PROGRAM &&
      cycIf.done);
   c_buffer: cover property (@(posedge clock) disable iff (!rst_b)
      state_r == fci_pkg::ST_ARG && op_r == fci_pkg::OP_BUFFER_WRITE &&
      cycIf.done);
   c_query: cover property (@(posedge clock) disable iff (!rst_b)
      rspValid && op_r == fci_pkg::OP_READ_QUERY &&
      addr_r[7:0] == fci_pkg::QUERY_BASE);
   c_erase: cover property (@(posedge clock) disable iff (!rst_b)
      state_r == fci_pkg::ST_ARG && op_r == fci_pkg::OP_BLOCK_ERASE &&
      cycIf.done);
endmodule : fci_host
`default_nettype wire

// ---- include/fci_pkg.sv ----
// Constants, codes and types of the flash command host
package fci_pkg;
   localparam int CLK_NS = 10;
   localparam int T_WP_NS = 50;
   localparam int T_ACC_NS = 100;
   localparam int T_RP_NS = 100;
   localparam int WE_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
   localparam int RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;
   localparam int SYNC_CYC = 2;
   localparam int ADDR_W = 22;
   localparam int DATA_W = 16;
   localparam int CNT_W = 5;
   localparam int BUF_WORD_AW = 4;
   localparam int READY_BIT = 7;
   localparam logic [7:0] QUERY_BASE = 8'h10;
   localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
   localparam logic [7:0] CMD_READ_ID = 8'h90;
   localparam logic [7:0] CMD_QUERY = 8'h98;
   localparam logic [7:0] CMD_STATUS = 8'h70;
   localparam logic [7:0] CMD_CLR_STATUS = 8'h50;
   localparam logic [7:0] CMD_BUFFER = 8'he8;
   localparam logic [7:0] CMD_PROGRAM = 8'h40;
   localparam logic [7:0] CMD_PROGRAM_ALT = 8'h10;
   localparam logic [7:0] CMD_ERASE = 8'h20;
   localparam logic [7:0] CMD_CHIP_ERASE = 8'h30;
   localparam logic [7:0] CMD_SUSPEND = 8'hb0;
   localparam logic [7:0] CMD_CONFIRM = 8'hd0;
   localparam logic [7:0] CMD_PIN_CFG = 8'hb8;
   localparam logic [7:0] CMD_LOCK = 8'h60;
   localparam logic [7:0] CMD_LOCK_SET = 8'h01;
   typedef enum logic [3:0] {
      OP_READ_ARRAY, OP_READ_ID, OP_READ_QUERY, OP_READ_STATUS,
      OP_CLEAR_STATUS, OP_PROGRAM, OP_BUFFER_WRITE, OP_BLOCK_ERASE,
      OP_CHIP_ERASE, OP_SUSPEND, OP_RESUME, OP_SET_LOCK, OP_CLEAR_LOCKS,
      OP_PIN_CONFIG
   } fci_op_e;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000, ST_CMD = 3'b001, ST_POLL = 3'b011,
      ST_CNT = 3'b010, ST_DATA = 3'b110, ST_ARG = 3'b111,
      ST_READ = 3'b101, ST_DONE = 3'b100
   } fci_state_e;
   typedef enum logic [1:0] {
      CS_IDLE = 2'b00, CS_SETUP = 2'b01, CS_STROBE = 2'b11, CS_HOLD = 2'b10
   } fci_cyc_e;
endpackage : fci_pkg

// ---- include/fci_cyc_if.sv ----
// Bus cycle request channel between sequencer and cycle engine
`timescale 1ns/100ps
`default_nettype none
interface fci_cyc_if;
   logic start;
   logic isWrite;
   logic busy;
   logic done;
   logic [21:0] addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   modport ctl(output start, isWrite, addr, wdata,
      input busy, done, rdata);
   modport cyc(input start, isWrite, addr, wdata,
      output busy, done, rdata);
endinterface : fci_cyc_if
`default_nettype wire

// ---- design/fci_bus_cycle.sv ----
// One asynchronous flash bus cycle, read or write, on the pins
`timescale 1ns/100ps
`default_nettype none
module fci_bus_cycle (
   input wire logic clock,
   input wire logic rst_b,
   fci_cyc_if.cyc cyc,
   output logic pinCeN,
   output logic pinOeN,
   output logic pinWeN,
   output logic [21:0] pinAddr,
   output logic [15:0] pinDqOut,
   output logic pinDqOe,
   input wire logic [15:0] pinDqIn
);
   localparam int WE_CHK = fci_pkg::WE_CYC;
   fci_pkg::fci_cyc_e state_r;
   logic [4:0] cnt_r;
   logic write_r;
   logic [15:0] dqMeta_r;
   logic [15:0] dqSync_r;

   assign cyc.busy = state_r != fci_pkg::CS_IDLE;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         dqMeta_r <= 16'h0000;
         dqSync_r <= 16'h0000;
      end else begin
         dqMeta_r <= pinDqIn;
         dqSync_r <= dqMeta_r;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= fci_pkg::CS_IDLE;
         cnt_r <= 5'h00;
         write_r <= 1'b0;
      end else begin
         unique case (state_r)
            fci_pkg::CS_IDLE: if (cyc.start) begin
               write_r <= cyc.isWrite;
               state_r <= fci_pkg::CS_SETUP;
            end
            fci_pkg::CS_SETUP: begin
               cnt_r <= write_r ? 5'(fci_pkg::WE_CYC - 1) :
                  5'(fci_pkg::ACC_CYC + fci_pkg::SYNC_CYC - 1);
               state_r <= fci_pkg::CS_STROBE;
            end
            fci_pkg::CS_STROBE: if (cnt_r == 5'h00) begin
               state_r <= fci_pkg::CS_HOLD;
            end else begin
               cnt_r <= cnt_r - 5'h01;
            end
            fci_pkg::CS_HOLD: state_r <= fci_pkg::CS_IDLE;
         endcase
      end
   end

   // Data stays driven across the rising write strobe so it is latched
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         pinCeN <= 1'b1;
         pinOeN <= 1'b1;
         pinWeN <= 1'b1;
         pinAddr <= 22'h000000;
         pinDqOut <= 16'h0000;
         pinDqOe <= 1'b0;
      end else begin
         if (state_r == fci_pkg::CS_IDLE && cyc.start) begin
            pinCeN <= 1'b0;
            pinAddr <= cyc.addr;
            pinDqOut <= cyc.wdata;
            pinDqOe <= cyc.isWrite;
         end
         if (state_r == fci_pkg::CS_SETUP) begin
            pinWeN <= !write_r;
            pinOeN <= write_r;
         end
         if (state_r == fci_pkg::CS_STROBE && cnt_r == 5'h00) begin
            pinWeN <= 1'b1;
            pinOeN <= 1'b1;
         end
         if (state_r == fci_pkg::CS_HOLD) begin
            pinCeN <= 1'b1;
            pinDqOe <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         cyc.rdata <= 16'h0000;
         cyc.done <= 1'b0;
      end else begin
         cyc.done <= state_r == fci_pkg::CS_HOLD;
         if (state_r == fci_pkg::CS_STROBE && cnt_r == 5'h00 && !write_r)
            cyc.rdata <= dqSync_r;
      end
   end

   a_we_data_held: assert property (
      @(posedge clock) disable iff (!rst_b)
      $rose(pinWeN) |-> pinDqOe && $stable(pinDqOut) && !pinCeN)
      else $error("write data not held at strobe rise");
   a_we_width: assert property (
      @(posedge clock) disable iff (!rst_b)
      $fell(pinWeN) |-> ##WE_CHK $rose(pinWeN))
      else $error("write strobe width wrong");
endmodule : fci_bus_cycle
`default_nettype wire

// ---- sim/fci_flash_model.sv ----
// Behavioural parallel flash device facing the command host
`timescale 1ns/100ps
`default_nettype none
module fci_flash_model #(
   parameter logic [15:0] MFR_CODE = 16'h00a5, // Arbitrary value
   parameter logic [15:0] DEV_CODE = 16'h005a // Arbitrary value
) (
   input wire logic ceN,
   input wire logic oeN,
   input wire logic weN,
   input wire logic [21:0] addr,
   input wire logic [15:0] dqIn,
   output logic [15:0] dqDrv,
   input wire logic byteN,
   input wire logic rpN,
   input wire logic wp
);
   logic [15:0] mem [64];
   logic [3:0] lockBits;
   logic [2:0] mode;
   logic [2:0] pend;
   logic [4:0] left;
   logic [7:0] stat;
   logic [15:0] rdVal;
   logic [15:0] lastOut = 16'h0000;
   logic suspended;
   logic badUpper;
   logic [7:0] qa;
   wire [1:0] blk = addr[17:16];
   wire [5:0] idx = addr[5:0];
   always @(posedge weN or negedge rpN) begin
      if (!rpN) begin
         mode <= 3'h0;
         pend <= 3'h0;
         stat <= 8'h80;
         suspended <= 1'b0;
         lockBits <= 4'h0;
      end else if (!ceN) begin
         case (pend)
            3'h1: begin
               if (lockBits[blk] && !wp) stat[4] <= 1'b1;
               else mem[idx] <= dqIn;
               pend <= 3'h0;
            end
            3'h2: begin
               if (dqIn[7:0] != 8'hd0) stat[4] <= 1'b1;
               pend <= 3'h0;
            end
            3'h3: begin
               left <= dqIn[4:0];
               pend <= 3'h4;
            end
            3'h4: begin
               mem[idx] <= dqIn;
               left <= left - 5'h01;
               if (left == 5'h00) pend <= 3'h2;
            end
            3'h5: begin
               if (dqIn[7:0] == 8'h01 && wp) lockBits[blk] <= 1'b1;
               if (dqIn[7:0] == 8'hd0 && wp) lockBits <= 4'h0;
               pend <= 3'h0;
            end
            3'h6: pend <= 3'h0;
            default: begin
               if (byteN && dqIn[15:8] != 8'h00) badUpper <= 1'b1;
               mode <= 3'h3;
               case (dqIn[7:0])
                  8'hff: mode <= 3'h0;
                  8'h90: mode <= 3'h1;
                  8'h98: mode <= 3'h2;
                  8'h50: stat <= 8'h80;
                  8'h40, 8'h10: pend <= 3'h1;
                  8'h20, 8'h30: pend <= 3'h2;
                  8'he8: pend <= 3'h3;
                  8'hb0: suspended <= 1'b1;
                  8'hd0: suspended <= 1'b0;
                  8'h60: pend <= 3'h5;
                  8'hb8: pend <= 3'h6;
                  default: ;
               endcase
            end
         endcase
      end
   end
   always_comb begin
      qa = byteN ? addr[7:0] : addr[8:1];
      case (mode)
         3'h0: rdVal = mem[idx];
         3'h1: rdVal = (addr[1:0] == 2'h0) ? MFR_CODE :
            (addr[1:0] == 2'h1) ? DEV_CODE : {15'h0000, lockBits[blk]};
         3'h2: rdVal = {byteN ? 8'h00 : ~lastOut[15:8],
            (qa == 8'h10) ? 8'h51 : (qa == 8'h11) ? 8'h52 :
            (qa == 8'h12) ? 8'h59 : 8'h00};
         default: rdVal = {8'h00, stat};
      endcase
   end
   always @(posedge oeN) lastOut <= dqDrv;
   // Released bus shows a changed pattern so stale data cannot pass
   assign dqDrv = (!ceN && !oeN && rpN) ? rdVal : ~lastOut;
   initial begin
      badUpper = 1'b0;
      for (int i = 0; i < 64; i++) mem[i] = 16'h0000;
   end
endmodule : fci_flash_model
`default_nettype wire

// ---- sim/tb_top.sv ----
// Self-checking bench for the flash command host
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic clock = 1'b0, rst_b = 1'b0, reqValid = 1'b0, byteMode = 1'b0;
   logic protectHigh = 1'b0, wrValid = 1'b0;
   fci_pkg::fci_op_e reqOp = fci_pkg::OP_READ_ARRAY;
   logic [21:0] reqAddr = 22'h000000;
   logic [15:0] reqData = 16'h0000, wrData = 16'h1111;
   logic [4:0] reqCount = 5'h00;
   logic reqReady, wrReady, rspValid, rspError, ceN, oeN, weN, dqOe;
   logic byteN, rpN, wp;
   logic [15:0] rspData, dqOut, dqDrv;
   logic [21:0] fAddr;
   int n_errors = 0, checked = 0, wIdx = 0;
   wire [15:0] dqBus = dqOe ? dqOut : dqDrv;
   fci_host dut (.clock(clock), .rst_b(rst_b), .reqValid(reqValid),
      .reqReady(reqReady), .reqOp(reqOp), .reqAddr(reqAddr),
      .reqData(reqData), .reqCount(reqCount), .byteMode(byteMode),
      .protectHigh(protectHigh), .wrValid(wrValid), .wrReady(wrReady),
      .wrData(wrData), .rspValid(rspValid), .rspError(rspError),
      .rspData(rspData), .flashCeN(ceN), .flashOeN(oeN), .flashWeN(weN),
      .flashAddr(fAddr), .flashDqOut(dqOut), .flashDqOe(dqOe),
      .flashDqIn(dqBus), .flashByteN(byteN), .flashRpN(rpN), .flashWp(wp));
   fci_flash_model fm (.ceN(ceN), .oeN(oeN), .weN(weN), .addr(fAddr),
      .dqIn(dqBus), .dqDrv(dqDrv), .byteN(byteN), .rpN(rpN), .wp(wp));
   initial forever #5 clock = ~clock;
   always @(posedge clock) if (wrValid && wrReady) begin
      wIdx <= wIdx + 1;
      wrData <= 16'h1111 * 16'(wIdx + 2);
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic req(input fci_pkg::fci_op_e op, input logic [21:0] a,
      input logic [15:0] d, input logic [4:0] n, input logic expErr);
      int i;
      @(posedge clock);
      reqOp <= op;
      reqAddr <= a;
      reqData <= d;
      reqCount <= n;
      reqValid <= 1'b1;
      i = 0;
      do @(negedge clock); while (reqReady !== 1'b1 && i++ < 500);
      @(posedge clock);
      reqValid <= 1'b0;
      i = 0;
      do @(negedge clock); while (rspValid !== 1'b1 && i++ < 3000);
      chk(16'(rspValid), 16'h0001);
      chk(16'(rspError), 16'(expErr));
   endtask : req
   task automatic t_reset();
      repeat (12) @(posedge clock);
      chk(16'({ceN, weN, oeN, rpN}), 16'h000e);
      rst_b <= 1'b1;
      req(fci_pkg::OP_READ_ARRAY, 22'h0, 16'h0, 5'h0, 1'b0);
   endtask : t_reset
   task automatic t_program();
      req(fci_pkg::OP_PROGRAM, 22'h000005, 16'hbeef, 5'h0, 1'b0);
      chk(fm.mem[5], 16'hbeef);
   endtask : t_program
   task automatic t_query(input logic x8);
      @(posedge clock);
      byteMode <= x8;
      req(fci_pkg::OP_READ_QUERY, 22'h000010, 16'h0, 5'h0, 1'b0);
      chk(rspData, 16'h5251);
      req(fci_pkg::OP_READ_QUERY, 22'h000011, 16'h0, 5'h0, 1'b0);
      chk(rspData, 16'h5952);
      @(posedge clock);
      byteMode <= 1'b0;
   endtask : t_query
   task automatic t_buffer();
      @(posedge clock);
      wrValid <= 1'b1;
      req(fci_pkg::OP_BUFFER_WRITE, 22'h000010, 16'h0, 5'h2, 1'b0);
      @(posedge clock);
      wrValid <= 1'b0;
      chk(fm.mem[16], 16'h1111);
      chk(fm.mem[18], 16'h3333);
      chk(fm.mem[19], 16'h0000);
      req(fci_pkg::OP_BUFFER_WRITE, 22'h00001e, 16'h0, 5'h3, 1'b1);
   endtask : t_buffer
   task automatic t_erase();
      req(fci_pkg::OP_BLOCK_ERASE, 22'h000000, 16'h0, 5'h0, 1'b0);
      req(fci_pkg::OP_READ_ARRAY, 22'h0, 16'h0, 5'h0, 1'b1);
      req(fci_pkg::OP_SUSPEND, 22'h0, 16'h0, 5'h0, 1'b0);
      chk(16'(fm.suspended), 16'h0001);
      req(fci_pkg::OP_RESUME, 22'h0, 16'h0, 5'h0, 1'b0);
      chk(16'(fm.suspended), 16'h0000);
      req(fci_pkg::OP_CHIP_ERASE, 22'h0, 16'h0, 5'h0, 1'b0);
      req(fci_pkg::OP_READ_STATUS, 22'h0, 16'h0, 5'h0, 1'b0);
      chk(rspData, 16'h0080);
      req(fci_pkg::OP_READ_ARRAY, 22'h0, 16'h0, 5'h0, 1'b0);
      chk(16'(fm.mode), 16'h0000);
   endtask : t_erase
   task automatic t_lock();
      req(fci_pkg::OP_SET_LOCK, 22'h010000, 16'h0, 5'h0, 1'b0);
      chk(16'(fm.lockBits), 16'h0002);
      req(fci_pkg::OP_PROGRAM, 22'h010007, 16'h7777, 5'h0, 1'b0);
      chk(fm.mem[7], 16'h0000);
      req(fci_pkg::OP_READ_STATUS, 22'h0, 16'h0, 5'h0, 1'b0);
      chk(rspData, 16'h0090);
      req(fci_pkg::OP_CLEAR_STATUS, 22'h0, 16'h0, 5'h0, 1'b0);
      req(fci_pkg::OP_READ_STATUS, 22'h0, 16'h0, 5'h0, 1'b0);
      chk(rspData, 16'h0080);
      @(posedge clock);
      protectHigh <= 1'b1;
      req(fci_pkg::OP_PROGRAM, 22'h010008, 16'h8888, 5'h0, 1'b0);
      chk(fm.mem[8], 16'h8888);
      @(posedge clock);
      protectHigh <= 1'b0;
      req(fci_pkg::OP_READ_ID, 22'h010002, 16'h0, 5'h0, 1'b0);
      chk(rspData, 16'h0001);
      req(fci_pkg::OP_READ_ID, 22'h000000, 16'h0, 5'h0, 1'b0);
      chk(rspData, 16'h00a5);
      req(fci_pkg::OP_CLEAR_LOCKS, 22'h0, 16'h0, 5'h0, 1'b0);
      chk(16'(fm.lockBits), 16'h0000);
      req(fci_pkg::OP_PROGRAM, 22'h010007, 16'h7777, 5'h0, 1'b0);
      chk(fm.mem[7], 16'h7777);
      req(fci_pkg::OP_PIN_CONFIG, 22'h0, 16'h0001, 5'h0, 1'b0);
      chk(16'(fm.badUpper), 16'h0000);
   endtask : t_lock
   task automatic give_verdict();
      $display("Counts: %0d mismatches, %0d checks", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : give_verdict
   initial begin
      t_reset();
      t_program();
      t_query(1'b0);
      t_query(1'b1);
      t_buffer();
      t_erase();
      t_lock();
      give_verdict();
   end
   initial begin
      #500000;
      n_errors++;
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
